// [rtl/e1rx_port.sv]
// Receive output port of an eight-channel E1 line interface: clock recovery,
// line decoding, loss of signal, violation reporting and the register port.
// Assumes sliced line pulses arrive on pins, asynchronous to rx_line_clk,
// and that rx_line_clk samples each bit period eight times.
//
// Function
// [RL1] Receiver-on input turns all channel receivers on together, off when low.
// [RL2] On loss of signal the channel flag goes high for at least one clock.
// [RL3] Loss flag stays high while the loss lasts, clears afterwards.
// [RL4] Each channel outputs a clock recovered from its line data stream.
// [RL5] Without signal the receive clock free-runs from the internal master clock.
// [RL6] Data outputs change on the recovered clock edge chosen by edge select.
// [RL7] Edge select is one global setting for all eight channels.
// [RL8] Dual-rail mode: negative pin carries decoded negative pulses.
// [RL9] Single-rail mode: negative pin is violation or overflow indicator, globally chosen.
// [RL10] Violation mode: indicator high one clock minimum on code violation or zeros.
// [RL11] Violation mode: indicator stays high while violations continue, then low.
// [RL12] Overflow mode: indicator goes high when the violation counter saturates.
// [RL13] Overflow mode: indicator stays high until the counter is reset.
// [RL14] Dual-rail mode: positive pin carries decoded positive pulses.
// [RL15] Single-rail mode: positive pin carries decoded NRZ data.
// [RL16] Mute input high with loss of signal forces both data outputs low.
// [RL17] Violation counter counts each violation, saturates, clears on reset.
// [RL18] Framer samples data on the recovered clock edge opposite the update edge.

`timescale 1ns/1ps
`default_nettype none

module e1rx_port
	import e1rx_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                srst,
	input  wire logic                rx_line_clk,
	input  wire logic [7:0]          addr,
	input  wire logic [31:0]         wr_data,
	input  wire logic                wr_en,
	input  wire logic                rd_en,
	output logic      [31:0]         rd_data,
	input  wire logic                receivers_on_input,
	input  wire logic                rx_data_mute_input,
	input  wire logic [CHANNELS-1:0] line_positive_input,
	input  wire logic [CHANNELS-1:0] line_negative_input,
	output logic      [CHANNELS-1:0] rx_clock_out,
	output logic      [CHANNELS-1:0] positive_rail_out,
	output logic      [CHANNELS-1:0] negative_rail_out,
	output logic      [CHANNELS-1:0] loss_of_signal_flag
);

	// ------------------------------------------------------------------
	// Register port (clk domain)
	// ------------------------------------------------------------------
	e1rx_sys_t           s;
	e1rx_sys_t           next_s;
	logic [CHANNELS-1:0] los_sys;
	logic [CHANNELS-1:0] ovf_sys;

	always_comb begin
		next_s         = s;
		next_s.rd_data = 32'h0000_0000;
		if (wr_en) begin
			unique case (addr)
				REG_CTRL: begin
					next_s.cfg.single_rail = wr_data[CTRL_SINGLE_RAIL_BIT];
					next_s.cfg.ovf_sel     = wr_data[CTRL_OVF_SEL_BIT];
					next_s.cfg.edge_rising = wr_data[CTRL_EDGE_RISING_BIT];
				end
				// [RL13] counter reset request
				REG_CNT_CLEAR: begin
					next_s.clr_tgl = s.clr_tgl ^ wr_data[CHANNELS-1:0];
				end
				default: begin
					next_s.clr_tgl = s.clr_tgl;
				end
			endcase
		end
		if (rd_en) begin
			unique case (addr)
				REG_CTRL: begin
					next_s.rd_data[CTRL_SINGLE_RAIL_BIT] = s.cfg.single_rail;
					next_s.rd_data[CTRL_OVF_SEL_BIT]     = s.cfg.ovf_sel;
					next_s.rd_data[CTRL_EDGE_RISING_BIT] = s.cfg.edge_rising;
				end
				REG_STATUS: begin
					next_s.rd_data[STATUS_LOS_LSB +: CHANNELS] = los_sys;
					next_s.rd_data[STATUS_OVF_LSB +: CHANNELS] = ovf_sys;
				end
				default: begin
					next_s.rd_data = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s.cfg     <= CFG_RESET;
			s.clr_tgl <= 8'h00;
			s.rd_data <= 32'h0000_0000;
		end else begin
			s <= next_s;
		end
	end

	assign rd_data = s.rd_data;

	// ------------------------------------------------------------------
	// Crossings into the line clock domain, and status back into the clk domain
	// ------------------------------------------------------------------
	// The line side gets its own synchronous reset; it releases two line
	// clocks after srst does, so the line clock must run during reset.
	logic                lrst;
	e1rx_cfg_t           cfg_l;
	logic [CHANNELS-1:0] clr_tgl_l;
	logic [CHANNELS-1:0] clr_tgl_d;
	logic                rx_on_l;
	logic                mute_l;

	e1rx_sync #(.W(1)) u_rst_sync (
		.clk (rx_line_clk),
		.d   (srst),
		.q   (lrst)
	);

	// Configuration bits are quasi-static, so a level sync per bit is enough.
	e1rx_sync #(.W(3 + CHANNELS + 2)) u_ctrl_sync (
		.clk (rx_line_clk),
		.d   ({s.cfg, s.clr_tgl, receivers_on_input, rx_data_mute_input}),
		.q   ({cfg_l, clr_tgl_l, rx_on_l, mute_l})
	);

	always_ff @(posedge rx_line_clk) begin
		if (lrst) begin
			clr_tgl_d <= 8'h00;
		end else begin
			clr_tgl_d <= clr_tgl_l;
		end
	end

	// Line pins are asynchronous to every clock here.
	logic [CHANNELS-1:0] pos_l;
	logic [CHANNELS-1:0] neg_l;

	e1rx_sync #(.W(2 * CHANNELS)) u_line_sync (
		.clk (rx_line_clk),
		.d   ({line_positive_input, line_negative_input}),
		.q   ({pos_l, neg_l})
	);

	logic [CHANNELS-1:0] los_l;
	logic [CHANNELS-1:0] ovf_l;

	e1rx_sync #(.W(2 * CHANNELS)) u_status_sync (
		.clk (clk),
		.d   ({los_l, ovf_l}),
		.q   ({los_sys, ovf_sys})
	);

	// ------------------------------------------------------------------
	// Per-channel receive logic (line clock domain)
	// ------------------------------------------------------------------
	for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
		e1rx_ch_t c;
		e1rx_ch_t next_c;
		logic     p;
		logic     n;
		logic     pulse;
		logic     bit_tick;
		logic     bpv;
		logic     sub_000v;
		logic     sub_b00v;
		logic     ez;
		logic     upd;
		logic     muted;
		logic     cnt_inc;
		logic     cnt_clr;
		logic     at_max;

		// [RL1] receivers gated off
		assign p     = pos_l[g] & rx_on_l;
		assign n     = neg_l[g] & rx_on_l;
		assign pulse = p | n;

		assign bit_tick = (c.phase == PH_SAMPLE);
		// A pulse of the same polarity as the last one is a bipolar violation.
		assign bpv      = pulse && (p == c.last_pos);
		assign sub_000v = bpv && (c.win[2:0] == 3'h0);
		assign sub_b00v = bpv && (c.win[2:0] == 3'h4);
		// [RL10] excess zeros detect
		// Every zero past the limit keeps the flag up, and the counter counts each such bit, so a long run adds one count per bit.
		assign ez       = !pulse && (c.zeros >= EXCESS_ZEROS);
		assign cnt_inc  = bit_tick && next_c.viol && !c.viol ? 1'b1 :
		                  bit_tick && next_c.viol;
		assign cnt_clr  = clr_tgl_l[g] ^ clr_tgl_d[g];

		// [RL17] saturating violation count
		e1rx_sat_counter #(.W(CNT_WIDTH)) u_cnt (
			.clk    (rx_line_clk),
			.rst    (lrst),
			.inc    (cnt_inc),
			.clr    (cnt_clr),
			.value  (),
			.at_max (at_max)
		);

		// [RL6] update edge select
		// [RL7] one global setting
		assign upd   = cfg_l.edge_rising ? (c.phase == PH_LAST) : (c.phase == PH_PRE_HALF);
		// [RL16] mute during loss
		assign muted = mute_l && c.los;

		always_comb begin
			next_c         = c;
			next_c.pulse_d = pulse;
			// [RL4] realign on line pulses
			// [RL5] free-run without signal
			// Realigning during loss too, so the first pulse back is sampled and ends the loss.
			if (pulse && !c.pulse_d) begin
				next_c.phase = PH_ALIGN;
			end else begin
				next_c.phase = c.phase + 3'h1;
			end
			next_c.rclk = (next_c.phase < PH_HALF);

			if (bit_tick) begin
				next_c.p_bit   = p;
				next_c.n_bit   = n;
				next_c.nrz_bit = c.win[3];
				// [RL11] flag follows each bit
				next_c.viol    = ez || (bpv && !sub_000v && !sub_b00v);
				next_c.win     = {c.win[2:0], pulse};
				if (sub_000v) begin
					next_c.win[0] = 1'b0;
				end
				if (sub_b00v) begin
					next_c.win[0] = 1'b0;
					next_c.win[3] = 1'b0;
				end
				if (pulse) begin
					next_c.last_pos = p;
					next_c.zeros    = 8'h00;
				end else if (c.zeros != 8'hFF) begin
					next_c.zeros = c.zeros + 8'h01;
				end
				// [RL2] loss set on zeros
				// [RL3] cleared by signal
				if (pulse) begin
					next_c.los = 1'b0;
				end else if (next_c.zeros >= LOS_ZEROS) begin
					next_c.los = 1'b1;
				end
			end

			if (upd) begin
				next_c.los_out = c.los;
				if (muted) begin
					next_c.pos_out = 1'b0;
					next_c.neg_out = 1'b0;
				end else if (cfg_l.single_rail) begin
					// [RL15] NRZ data
					next_c.pos_out = c.nrz_bit;
					// [RL9] indicator select
					// [RL12] overflow shown
					// [RL13] held until clear
					next_c.neg_out = cfg_l.ovf_sel ? at_max : c.viol;
				end else begin
					// [RL14] positive rail
					next_c.pos_out = c.p_bit;
					// [RL8] negative rail
					next_c.neg_out = c.n_bit;
				end
			end
		end

		always_ff @(posedge rx_line_clk) begin
			if (lrst) begin
				c <= '0;
			end else begin
				c <= next_c;
			end
		end

		// [RL18] framer samples opposite edge
		assign rx_clock_out[g]        = c.rclk;
		assign positive_rail_out[g]   = c.pos_out;
		assign negative_rail_out[g]   = c.neg_out;
		assign loss_of_signal_flag[g] = c.los_out;
		assign los_l[g]               = c.los;
		assign ovf_l[g]               = at_max;
	end

endmodule : e1rx_port

`default_nettype wire

// [rtl/e1rx_pkg.sv]
// Constants, field layouts and carrier types for the E1 receive output port.
// Assumes a 200 MHz register clock and a line-side sampling clock of its own.

package e1rx_pkg;

	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int CHANNELS  = 8;
	localparam int CNT_WIDTH = 16;
	localparam int PH_WIDTH  = 3;

	// ------------------------------------------------------------------
	// Register map (byte offsets) and field positions
	// ------------------------------------------------------------------
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_CNT_CLEAR = 8'h04;
	localparam logic [7:0] REG_STATUS    = 8'h08;
	localparam int CTRL_SINGLE_RAIL_BIT  = 0;
	localparam int CTRL_OVF_SEL_BIT      = 1;
	localparam int CTRL_EDGE_RISING_BIT  = 2;
	localparam int STATUS_LOS_LSB        = 0;
	localparam int STATUS_OVF_LSB        = 8;

	// ------------------------------------------------------------------
	// Line timing: phases in line clock cycles, zero limits in bit periods
	// ------------------------------------------------------------------
	localparam logic [PH_WIDTH-1:0] PH_SAMPLE    = 3'h2;
	localparam logic [PH_WIDTH-1:0] PH_ALIGN     = 3'h1;
	localparam logic [PH_WIDTH-1:0] PH_HALF      = 3'h4;
	localparam logic [PH_WIDTH-1:0] PH_LAST      = 3'h7;
	localparam logic [PH_WIDTH-1:0] PH_PRE_HALF  = 3'h3;
	localparam logic [7:0]          LOS_ZEROS    = 8'h20;
	localparam logic [7:0]          EXCESS_ZEROS = 8'h03;

	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic edge_rising;
		logic ovf_sel;
		logic single_rail;
	} e1rx_cfg_t;

	localparam e1rx_cfg_t CFG_RESET = '{edge_rising: 1'b0, ovf_sel: 1'b0, single_rail: 1'b0};

	typedef struct packed {
		e1rx_cfg_t             cfg;
		logic [CHANNELS-1:0]   clr_tgl;
		logic [31:0]           rd_data;
	} e1rx_sys_t;

	typedef struct packed {
		logic [PH_WIDTH-1:0] phase;
		logic                pulse_d;
		logic                last_pos;
		logic [3:0]          win;
		logic [7:0]          zeros;
		logic                los;
		logic                p_bit;
		logic                n_bit;
		logic                nrz_bit;
		logic                viol;
		logic                rclk;
		logic                pos_out;
		logic                neg_out;
		logic                los_out;
	} e1rx_ch_t;

endpackage : e1rx_pkg

// [rtl/e1rx_sync.sv]
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; multi-bit words need a handshake instead.

`timescale 1ns/1ps
`default_nettype none

module e1rx_sync
	import e1rx_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} e1rx_sync_t;

	e1rx_sync_t r;
	e1rx_sync_t next_r;

	// The first stage feeds only the second stage.
	always_comb begin
		next_r.meta   = d;
		next_r.stable = r.meta;
	end

	always_ff @(posedge clk) begin
		r <= next_r;
	end

	assign q = r.stable;

endmodule : e1rx_sync

`default_nettype wire

// [rtl/e1rx_sat_counter.sv]
// Saturating event counter with synchronous clear.
// Assumes inc and clr come from the same clock domain as clk.

`timescale 1ns/1ps
`default_nettype none

module e1rx_sat_counter
	import e1rx_pkg::*;
#(
	parameter int W = CNT_WIDTH
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         inc,
	input  wire logic         clr,
	output logic      [W-1:0] value,
	output logic              at_max
);

	typedef struct packed {
		logic [W-1:0] count;
	} e1rx_cnt_t;

	e1rx_cnt_t r;
	e1rx_cnt_t next_r;

	always_comb begin
		next_r = r;
		if (clr) begin
			// An event in the clearing cycle is kept rather than lost.
			next_r.count    = '0;
			next_r.count[0] = inc;
		end else if (inc && !at_max) begin
			next_r.count = r.count + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r.count <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign value  = r.count;
	assign at_max = &r.count;

endmodule : e1rx_sat_counter

`default_nettype wire

// [verification/e1rx_port_asserts.sv]
// Checker bound to e1rx_port; it watches only the top ports.
// The edge choice is tracked from CTRL writes seen on the register port.
`timescale 1ns/1ps
`default_nettype none
module e1rx_port_asserts
	import e1rx_pkg::*;
(
	input wire logic                clk,
	input wire logic                srst,
	input wire logic                rx_line_clk,
	input wire logic [7:0]          addr,
	input wire logic [31:0]         wr_data,
	input wire logic                wr_en,
	input wire logic                rd_en,
	input wire logic [31:0]         rd_data,
	input wire logic                receivers_on_input,
	input wire logic                rx_data_mute_input,
	input wire logic [CHANNELS-1:0] line_positive_input,
	input wire logic [CHANNELS-1:0] line_negative_input,
	input wire logic [CHANNELS-1:0] rx_clock_out,
	input wire logic [CHANNELS-1:0] positive_rail_out,
	input wire logic [CHANNELS-1:0] negative_rail_out,
	input wire logic [CHANNELS-1:0] loss_of_signal_flag
);
	logic       edge_r;
	logic       edge_l;
	logic [3:0] settle;
	logic [8:0] off_cnt;
	logic [4:0] mute_cnt;
	logic [3:0] quiet;
	logic [3:0] still;
	always_ff @(posedge clk) begin
		if (srst)
			edge_r <= 1'b0;
		else if (wr_en && addr == REG_CTRL)
			edge_r <= wr_data[CTRL_EDGE_RISING_BIT];
	end
	// Edge checks wait until a new edge choice has surely crossed over.
	always_ff @(posedge rx_line_clk) begin
		edge_l <= edge_r;
		settle <= (srst || edge_l != edge_r) ? 4'h0 : settle + {3'h0, settle != 4'hF};
		off_cnt <= (srst || receivers_on_input) ? 9'h000 : off_cnt + {8'h00, off_cnt != 9'h1FF};
		mute_cnt <= (!srst && rx_data_mute_input && loss_of_signal_flag[0]) ?
			mute_cnt + {4'h0, mute_cnt != 5'h1F} : 5'h00;
		quiet <= (srst || line_positive_input[0] || line_negative_input[0]) ? 4'h0 :
			quiet + {3'h0, quiet != 4'hF};
		still <= (srst || $changed(rx_clock_out[0])) ? 4'h0 : still + {3'h0, still != 4'hF};
	end
	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence s_los_hold;
		loss_of_signal_flag[0] [*8];
	endsequence
	AST_RD_IDLE: assert property (@(posedge clk) disable iff (srst)
		!$past(rd_en) |-> rd_data == 32'h0) else $error("read data not idle");
	AST_LOS_HOLD: assert property (@(posedge rx_line_clk) disable iff (srst)
		$rose(loss_of_signal_flag[0]) |-> s_los_hold) else $error("loss flag too short");
	AST_LOS_CLEAR: assert property (@(posedge rx_line_clk) disable iff (srst)
		$fell(loss_of_signal_flag[0]) |-> quiet < 4'h8) else $error("loss cleared unprompted");
	AST_CLK_RUNS: assert property (@(posedge rx_line_clk) disable iff (srst)
		still < 4'hC) else $error("receive clock stopped");
	AST_EDGE_CH0: assert property (@(posedge rx_line_clk) disable iff (srst)
		settle == 4'hF && !loss_of_signal_flag[0] && !$past(loss_of_signal_flag[0]) &&
		$changed(positive_rail_out[0]) |->
		(edge_l ? $rose(rx_clock_out[0]) : $fell(rx_clock_out[0]))) else $error("bad edge ch0");
	AST_EDGE_CH7: assert property (@(posedge rx_line_clk) disable iff (srst)
		settle == 4'hF && !loss_of_signal_flag[7] && !$past(loss_of_signal_flag[7]) &&
		$changed(negative_rail_out[7]) |->
		(edge_l ? $rose(rx_clock_out[7]) : $fell(rx_clock_out[7]))) else $error("bad edge ch7");
	AST_RX_OFF: assert property (@(posedge rx_line_clk) disable iff (srst)
		off_cnt >= 9'h140 |-> loss_of_signal_flag == 8'hFF) else $error("receivers not off");
	AST_MUTE: assert property (@(posedge rx_line_clk) disable iff (srst)
		mute_cnt >= 5'h14 |-> !positive_rail_out[0] && !negative_rail_out[0])
		else $error("data not muted");
endmodule : e1rx_port_asserts
bind e1rx_port e1rx_port_asserts u_e1rx_port_asserts (
	.clk, .srst, .rx_line_clk, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
	.receivers_on_input, .rx_data_mute_input, .line_positive_input, .line_negative_input,
	.rx_clock_out, .positive_rail_out, .negative_rail_out, .loss_of_signal_flag
);
`default_nettype wire

// [verification/e1rx_framer_model.sv]
// Downstream framer model for one channel: counts ones on each rail.
// Assumes clr is pulsed before every counted stretch.
`timescale 1ns/1ps
`default_nettype none
module e1rx_framer_model
	import e1rx_pkg::*;
(
	input wire logic        rclk,
	input wire logic        edge_rising,
	input wire logic        pos,
	input wire logic        neg,
	input wire logic        clr,
	output logic     [15:0] pos_ones,
	output logic     [15:0] neg_ones
);
	always @(rclk or posedge clr) begin
		if (clr) begin
			pos_ones = 16'h0000;
			neg_ones = 16'h0000;
		end else if (rclk !== edge_rising) begin
			pos_ones = pos_ones + {15'h0000, pos};
			neg_ones = neg_ones + {15'h0000, neg};
		end
	end
endmodule : e1rx_framer_model
`default_nettype wire

// [verification/testbench.sv]
// Bench for e1rx_port: register port tasks, line symbols on all channels,
// framer model on channel 0. Assumes the line clock runs from time zero.
`timescale 1ns/1ps
`default_nettype none
module testbench
	import e1rx_pkg::*;
;
	logic clk, srst, rx_line_clk, wr_en, rd_en, edge_sel, fr_clr;
	logic receivers_on_input, rx_data_mute_input;
	logic [7:0] addr;
	logic [31:0] wr_data, rd_data, rd;
	logic [CHANNELS-1:0] line_positive_input, line_negative_input, rx_clock_out;
	logic [CHANNELS-1:0] positive_rail_out, negative_rail_out, loss_of_signal_flag;
	logic [15:0] pos_ones, neg_ones;
	int error_cnt;
	int num_checks;
	e1rx_port u_e1rx_port (
		.clk, .srst, .rx_line_clk, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
		.receivers_on_input, .rx_data_mute_input, .line_positive_input,
		.line_negative_input, .rx_clock_out, .positive_rail_out,
		.negative_rail_out, .loss_of_signal_flag
	);
	e1rx_framer_model u_framer (
		.rclk(rx_clock_out[0]), .edge_rising(edge_sel), .pos(positive_rail_out[0]),
		.neg(negative_rail_out[0]), .clr(fr_clr), .pos_ones, .neg_ones
	);
	always #2.5 clk = ~clk;
	initial begin
		rx_line_clk = 1'b0;
		#13.7;
		forever #40 rx_line_clk = ~rx_line_clk;
	end
	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask : bus_rd
	// One symbol per bit period of 127 clocks, as a half-bit pulse.
	task automatic seq(input string p);
		for (int i = 0; i < p.len(); i++) begin
			@(posedge clk);
			line_positive_input <= {CHANNELS{p[i] == "+"}};
			line_negative_input <= {CHANNELS{p[i] == "-"}};
			repeat (63) @(posedge clk);
			line_positive_input <= '0;
			line_negative_input <= '0;
			repeat (63) @(posedge clk);
		end
	endtask : seq
	task automatic clear_fr();
		@(posedge clk);
		fr_clr <= 1'b1;
		@(posedge clk);
		fr_clr <= 1'b0;
	endtask : clear_fr
	task automatic test_done();
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		test_done();
	end
	// Reset spans six line clocks so the line side sees it too.
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		addr = 8'h00;
		wr_data = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		receivers_on_input = 1'b1;
		rx_data_mute_input = 1'b1;
		line_positive_input = '0;
		line_negative_input = '0;
		edge_sel = 1'b0;
		fr_clr = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		repeat (6) @(posedge rx_line_clk);
		@(posedge clk);
		srst <= 1'b0;
		bus_rd(REG_CTRL, rd);
		check(rd, 32'(CFG_RESET));
		bus_wr(REG_CTRL, 32'h7);
		bus_wr(REG_STATUS, 32'hFFFF_FFFF);
		bus_rd(REG_CTRL, rd);
		check(rd, 32'h7);
		bus_rd(8'h0C, rd);
		check(rd, 32'h0);
		bus_wr(REG_CTRL, 32'h0);
		repeat (40) seq("0");
		bus_rd(REG_STATUS, rd);
		check(rd, 32'h0000_00FF);
		rx_data_mute_input <= 1'b0;
		for (int e = 0; e < 2; e++) begin
			bus_wr(REG_CTRL, 32'(e) << CTRL_EDGE_RISING_BIT);
			edge_sel <= e[0];
			seq("+-+-000");
			clear_fr();
			seq("+-+-+-+-+-+-+-+-000");
			check(32'(pos_ones), 32'h8);
			check(32'(neg_ones), 32'h8);
		end
		bus_wr(REG_CTRL, 32'h1);
		edge_sel <= 1'b0;
		seq("+-+-+-+-");
		clear_fr();
		seq("+-++-+-+-+-+-+-+");
		check(32'(neg_ones), 32'h1);
		check(32'(pos_ones >= 16'hE), 32'h1);
		seq("0000000000");
		check(32'(neg_ones > 16'h1), 32'h1);
		bus_wr(REG_CTRL, 32'h3);
		seq("+-");
		clear_fr();
		seq("+-+-+-+-");
		check(32'(neg_ones), 32'h0);
		bus_wr(REG_CNT_CLEAR, 32'hFF);
		bus_rd(REG_STATUS, rd);
		check(rd, 32'h0);
		bus_wr(REG_CTRL, 32'h1);
		receivers_on_input <= 1'b0;
		repeat (24) seq("+-");
		bus_rd(REG_STATUS, rd);
		check(rd, 32'h0000_00FF);
		clear_fr();
		seq("0000");
		check(32'(neg_ones > 16'h0), 32'h1);
		rx_data_mute_input <= 1'b1;
		seq("00");
		clear_fr();
		seq("0000");
		check(32'(neg_ones), 32'h0);
		receivers_on_input <= 1'b1;
		seq("+-+-000");
		bus_rd(REG_STATUS, rd);
		check(rd, 32'h0);
		test_done();
	end
endmodule : testbench
`default_nettype wire
